/* design/mpcr_cap_regs.sv */
`timescale 1ns/100ps
module mpcr_cap_regs
  import mpcr_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   reset,
  input  wire logic   cfg_wr_en,
  input  wire logic   cfg_rd_en,
  input  wire logic [3:0]  cfg_index,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic        cfg_rd_valid,
  input  wire logic   cfg_type0_cap,
  input  wire logic [7:0]  cap_bus_num,
  input  wire logic [4:0]  cap_dev_num,
  input  wire logic [2:0]  cap_func_num,
  input  wire logic   speed_strap_pin,
  input  wire logic   width_strap_pin,
  input  wire logic   pcix_mode,
  input  wire logic   master_dpe_flag,
  input  wire logic   split_err_msg_evt,
  input  wire logic   unexp_split_evt,
  input  wire logic   split_discard_evt,
  input  wire logic   seq_prepare,
  output logic [3:0]  seq_split_limit,
  output logic [11:0] seq_read_bytes,
  input  wire logic   irq_request,
  output logic        legacy_interrupt_pins_n,
  output logic        serr_n,
  input  wire logic   msg_ack,
  output logic        msg_valid,
  output logic [63:0] msg_addr,
  output logic        msg_dac,
  output logic [31:0] msg_data
);

  mpcr_msg_if msg_bus ();  // carrier to the message former

  // software-visible state
  logic        msi_en_reg,      msi_en_next;      // message enable
  logic [2:0]  msi_mme_reg,     msi_mme_next;     // messages allocated
  logic [29:0] addr_lo_reg,     addr_lo_next;     // msi_target_address_low [31:2]
  logic [31:0] addr_hi_reg,     addr_hi_next;     // msi_target_address_high
  logic [15:0] payload_reg,     payload_next;     // msi_payload
  logic [2:0]  split_code_reg,  split_code_next;  // command split limit code
  logic [1:0]  rdbc_code_reg,   rdbc_code_next;   // command read byte count code
  logic        recov_en_reg,    recov_en_next;    // parity recovery enable
  logic        st_err_reg,      st_err_next;      // received split error flag
  logic        st_unexp_reg,    st_unexp_next;    // unexpected split flag
  logic        st_disc_reg,     st_disc_next;     // discarded split flag
  logic [7:0]  bus_num_reg,     bus_num_next;     // captured bus number
  logic [4:0]  dev_num_reg,     dev_num_next;     // captured device number
  logic [2:0]  func_num_reg,    func_num_next;    // captured function number

  // strap handling
  logic [1:0]  spd_sync_reg,    wid_sync_reg;     // two-stage synchronisers
  logic [1:0]  strap_cnt_reg,   strap_cnt_next;   // wait after reset release
  logic        strap_done_reg,  strap_done_next;  // straps captured
  logic        cap133_reg,      cap133_next;      // 133 MHz capable
  logic        cap64_reg,       cap64_next;       // 64-bit device

  // outputs and side logic
  logic [31:0] rdata_reg,       rdata_next;       // read data
  logic        rd_valid_reg,    rd_valid_next;    // read answer strobe
  logic [3:0]  seq_split_reg,   seq_split_next;   // limit bound to a sequence
  logic [11:0] seq_rdbc_reg,    seq_rdbc_next;    // read count bound to a sequence
  logic        dpe_prev_reg,    dpe_prev_next;    // parity status last cycle
  logic        serr_n_reg,      serr_n_next;      // serr request, active low
  logic        irq_prev_reg,    irq_prev_next;    // interrupt request last cycle
  logic        pend_reg,        pend_next;        // message awaiting the former
  logic        fire_reg,        fire_next;        // one-cycle start to the former
  logic        legacy_n_reg,    legacy_n_next;    // legacy pin, active low

  logic [15:0] msi_ctrl;     // assembled message control half
  logic [15:0] pcix_cmd;     // assembled command half
  logic [31:0] pcix_stat;    // assembled status dword
  logic        wr_cmd;       // write hits the command byte
  logic        wr_stat;      // write hits the status dword

  // byte-enable merge of a write into a dword
  function automatic logic [31:0] be_merge(input logic [31:0] old_val,
                                           input logic [31:0] new_val,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // read images of the capability fields
  always_comb begin
    msi_ctrl                 = 16'h0000;
    msi_ctrl[MPCR_MC_EN_BIT] = msi_en_reg;
    msi_ctrl[3:1]            = MPCR_MC_MMC_VAL;
    msi_ctrl[6:4]            = msi_mme_reg;
    msi_ctrl[MPCR_MC_64_BIT] = 1'b1;
    pcix_cmd                     = 16'h0000;
    pcix_cmd[6:4]                = split_code_reg;
    pcix_cmd[3:2]                = rdbc_code_reg;
    pcix_cmd[MPCR_CMD_RECOV_BIT] = recov_en_reg;
    pcix_stat                    = 32'h0000_0000;
    pcix_stat[MPCR_ST_SPLIT_ERR] = st_err_reg;
    pcix_stat[28:26]             = MPCR_ST_CUM_READ;
    pcix_stat[25:23]             = MPCR_ST_DES_SPLIT;
    pcix_stat[22:21]             = MPCR_ST_DES_RDBC;
    pcix_stat[20]                = MPCR_ST_COMPLEX;
    pcix_stat[MPCR_ST_UNEXP]     = st_unexp_reg;
    pcix_stat[MPCR_ST_DISCARD]   = st_disc_reg;
    pcix_stat[17]                = cap133_reg;
    pcix_stat[16]                = cap64_reg;
    pcix_stat[15:0]              = {bus_num_reg, dev_num_reg, func_num_reg};
  end

  assign wr_cmd  = cfg_wr_en && (cfg_index == MPCR_IDX_PCIX_CMD) && cfg_be[2];
  assign wr_stat = cfg_wr_en && (cfg_index == MPCR_IDX_PCIX_STAT);

  // register file writes and hardware updates
  always_comb begin
    logic [31:0] m;
    m               = 32'h0;
    msi_en_next     = msi_en_reg;
    msi_mme_next    = msi_mme_reg;
    addr_lo_next    = addr_lo_reg;
    addr_hi_next    = addr_hi_reg;
    payload_next    = payload_reg;
    split_code_next = split_code_reg;
    rdbc_code_next  = rdbc_code_reg;
    recov_en_next   = recov_en_reg;
    bus_num_next    = bus_num_reg;
    dev_num_next    = dev_num_reg;
    func_num_next   = func_num_reg;
    if (cfg_wr_en) begin
      case (cfg_index)
        MPCR_IDX_MSI_CTRL: begin
          // only enable and allocation bits are writable
          if (cfg_be[2]) begin
            msi_en_next  = cfg_wdata[16 + MPCR_MC_EN_BIT];
            msi_mme_next = cfg_wdata[22:20];
          end
        end
        MPCR_IDX_MSI_ADDR_L: begin
          // low two bits stay zero whatever is written
          m            = be_merge({addr_lo_reg, 2'b00}, cfg_wdata, cfg_be);
          addr_lo_next = m[31:2];
        end
        MPCR_IDX_MSI_ADDR_H: begin
          addr_hi_next = be_merge(addr_hi_reg, cfg_wdata, cfg_be);
        end
        MPCR_IDX_MSI_DATA: begin
          m            = be_merge({16'h0000, payload_reg}, cfg_wdata, cfg_be);
          payload_next = m[15:0];
        end
        MPCR_IDX_PCIX_CMD: begin
          // id and link bytes are read-only
          if (wr_cmd) begin
            split_code_next = cfg_wdata[22:20];
            rdbc_code_next  = cfg_wdata[19:18];
            recov_en_next   = cfg_wdata[16 + MPCR_CMD_RECOV_BIT];
          end
        end
        default: begin
          // status and unmapped indices hold no plain storage
          m = 32'h0;
        end
      endcase
    end
    // identity taken from type 0 configuration cycles
    if (cfg_type0_cap) begin
      bus_num_next  = cap_bus_num;
      dev_num_next  = cap_dev_num;
      func_num_next = cap_func_num;
    end
  end

  // sticky status flags: set beats a simultaneous clear
  always_comb begin
    st_err_next   = st_err_reg;
    st_unexp_next = st_unexp_reg;
    st_disc_next  = st_disc_reg;
    if (wr_stat && cfg_be[3] && cfg_wdata[MPCR_ST_SPLIT_ERR]) begin
      st_err_next = 1'b0;
    end
    if (wr_stat && cfg_be[2] && cfg_wdata[MPCR_ST_UNEXP]) begin
      st_unexp_next = 1'b0;
    end
    if (wr_stat && cfg_be[2] && cfg_wdata[MPCR_ST_DISCARD]) begin
      st_disc_next = 1'b0;
    end
    if (split_err_msg_evt) begin
      st_err_next = 1'b1;
    end
    if (unexp_split_evt) begin
      st_unexp_next = 1'b1;
    end
    if (split_discard_evt) begin
      st_disc_next = 1'b1;
    end
  end

  // strap capture a fixed delay after reset release; low pin sets the bit
  always_comb begin
    strap_cnt_next  = strap_cnt_reg;
    strap_done_next = strap_done_reg;
    cap133_next     = cap133_reg;
    cap64_next      = cap64_reg;
    if (!strap_done_reg) begin
      if (strap_cnt_reg == MPCR_STRAP_WAIT) begin
        cap133_next     = ~spd_sync_reg[1];
        cap64_next      = ~wid_sync_reg[1];
        strap_done_next = 1'b1;
      end else begin
        strap_cnt_next = strap_cnt_reg + 2'h1;
      end
    end
  end

  // read path, sequence binding, serr and interrupt routing
  always_comb begin
    rdata_next     = rdata_reg;
    rd_valid_next  = cfg_rd_en;
    seq_split_next = seq_split_reg;
    seq_rdbc_next  = seq_rdbc_reg;
    dpe_prev_next  = master_dpe_flag;
    serr_n_next    = 1'b1;
    irq_prev_next  = irq_request;
    pend_next      = pend_reg;
    fire_next      = 1'b0;
    legacy_n_next  = 1'b1;
    if (cfg_rd_en) begin
      case (cfg_index)
        MPCR_IDX_MSI_CTRL:   rdata_next = {msi_ctrl, MPCR_NEXT_PTR_RST, MPCR_MSI_CAP_ID};
        MPCR_IDX_MSI_ADDR_L: rdata_next = {addr_lo_reg, 2'b00};
        MPCR_IDX_MSI_ADDR_H: rdata_next = addr_hi_reg;
        MPCR_IDX_MSI_DATA:   rdata_next = {16'h0000, payload_reg};
        MPCR_IDX_PCIX_CMD:   rdata_next = {pcix_cmd, MPCR_NEXT_PTR_RST, MPCR_PCIX_CAP_ID};
        MPCR_IDX_PCIX_STAT:  rdata_next = pcix_stat;
        default:             rdata_next = 32'h0000_0000;
      endcase
    end
    // settings are frozen per sequence at preparation time
    if (seq_prepare) begin
      case (split_code_reg)
        3'h0:    seq_split_next = MPCR_SPLIT_1;
        3'h1:    seq_split_next = MPCR_SPLIT_2;
        3'h2:    seq_split_next = MPCR_SPLIT_3;
        3'h3:    seq_split_next = MPCR_SPLIT_4;
        3'h4:    seq_split_next = MPCR_SPLIT_8;
        default: seq_split_next = MPCR_SPLIT_1;  // reserved codes fall back to one
      endcase
      case (rdbc_code_reg)
        2'h0:    seq_rdbc_next = MPCR_RDBC_512;
        2'h1:    seq_rdbc_next = MPCR_RDBC_1024;
        2'h2:    seq_rdbc_next = MPCR_RDBC_2048;
        default: seq_rdbc_next = MPCR_RDBC_512;  // reserved code falls back to 512
      endcase
    end
    // new master parity error without recovery in pcix mode
    if (master_dpe_flag && !dpe_prev_reg && !recov_en_reg && pcix_mode) begin
      serr_n_next = 1'b0;
    end
    // legacy pin only while messages are disabled
    if (irq_request && !msi_en_reg) begin
      legacy_n_next = 1'b0;
    end
    // a new request becomes one message write when enabled and none is pending
    if (irq_request && !irq_prev_reg && msi_en_reg) begin
      pend_next = 1'b1;
    end
    if (pend_reg && !msg_bus.busy && !fire_reg) begin
      fire_next = 1'b1;
      pend_next = 1'b0;
    end
  end

  // registers of every group
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      msi_en_reg     <= 1'b0;
      msi_mme_reg    <= MPCR_MC_MME_RST;
      addr_lo_reg    <= 30'h0;
      addr_hi_reg    <= 32'h0;
      payload_reg    <= 16'h0;
      split_code_reg <= MPCR_CMD_SPLIT_RST;
      rdbc_code_reg  <= MPCR_CMD_RDBC_RST;
      recov_en_reg   <= 1'b0;
      st_err_reg     <= 1'b0;
      st_unexp_reg   <= 1'b0;
      st_disc_reg    <= 1'b0;
      bus_num_reg    <= 8'h0;
      dev_num_reg    <= 5'h0;
      func_num_reg   <= 3'h0;
      spd_sync_reg   <= 2'h0;
      wid_sync_reg   <= 2'h0;
      strap_cnt_reg  <= 2'h0;
      strap_done_reg <= 1'b0;
      cap133_reg     <= 1'b0;
      cap64_reg      <= 1'b0;
      rdata_reg      <= 32'h0;
      rd_valid_reg   <= 1'b0;
      seq_split_reg  <= MPCR_SPLIT_1;
      seq_rdbc_reg   <= MPCR_RDBC_512;
      dpe_prev_reg   <= 1'b0;
      serr_n_reg     <= 1'b1;
      irq_prev_reg   <= 1'b0;
      pend_reg       <= 1'b0;
      fire_reg       <= 1'b0;
      legacy_n_reg   <= 1'b1;
    end else begin
      msi_en_reg     <= msi_en_next;
      msi_mme_reg    <= msi_mme_next;
      addr_lo_reg    <= addr_lo_next;
      addr_hi_reg    <= addr_hi_next;
      payload_reg    <= payload_next;
      split_code_reg <= split_code_next;
      rdbc_code_reg  <= rdbc_code_next;
      recov_en_reg   <= recov_en_next;
      st_err_reg     <= st_err_next;
      st_unexp_reg   <= st_unexp_next;
      st_disc_reg    <= st_disc_next;
      bus_num_reg    <= bus_num_next;
      dev_num_reg    <= dev_num_next;
      func_num_reg   <= func_num_next;
      spd_sync_reg   <= {spd_sync_reg[0], speed_strap_pin};
      wid_sync_reg   <= {wid_sync_reg[0], width_strap_pin};
      strap_cnt_reg  <= strap_cnt_next;
      strap_done_reg <= strap_done_next;
      cap133_reg     <= cap133_next;
      cap64_reg      <= cap64_next;
      rdata_reg      <= rdata_next;
      rd_valid_reg   <= rd_valid_next;
      seq_split_reg  <= seq_split_next;
      seq_rdbc_reg   <= seq_rdbc_next;
      dpe_prev_reg   <= dpe_prev_next;
      serr_n_reg     <= serr_n_next;
      irq_prev_reg   <= irq_prev_next;
      pend_reg       <= pend_next;
      fire_reg       <= fire_next;
      legacy_n_reg   <= legacy_n_next;
    end
  end

  // carrier into the message former
  assign msg_bus.fire    = fire_reg;
  assign msg_bus.addr_lo = addr_lo_reg;
  assign msg_bus.addr_hi = addr_hi_reg;
  assign msg_bus.payload = payload_reg;

  // message write builder
  mpcr_msg_former u_former (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .msg       (msg_bus),
    .msg_ack   (msg_ack),
    .msg_valid (msg_valid),
    .msg_addr  (msg_addr),
    .msg_dac   (msg_dac),
    .msg_data  (msg_data)
  );

  assign cfg_rdata               = rdata_reg;
  assign cfg_rd_valid            = rd_valid_reg;
  assign seq_split_limit         = seq_split_reg;
  assign seq_read_bytes          = seq_rdbc_reg;
  assign serr_n                  = serr_n_reg;
  assign legacy_interrupt_pins_n = legacy_n_reg;

endmodule // mpcr_cap_regs

/* shared/mpcr_pkg.sv */
package mpcr_pkg;

  // dword indices of the configuration windows of this block
  localparam logic [3:0]  MPCR_IDX_MSI_CTRL   = 4'h0;  // msi id, link, control
  localparam logic [3:0]  MPCR_IDX_MSI_ADDR_L = 4'h1;  // msi_target_address_low
  localparam logic [3:0]  MPCR_IDX_MSI_ADDR_H = 4'h2;  // msi_target_address_high
  localparam logic [3:0]  MPCR_IDX_MSI_DATA   = 4'h3;  // msi_payload
  localparam logic [3:0]  MPCR_IDX_PCIX_CMD   = 4'h4;  // id, link, pcix_command_control
  localparam logic [3:0]  MPCR_IDX_PCIX_STAT  = 4'h5;  // pcix_status_report

  // fixed identifier values
  localparam logic [7:0]  MPCR_MSI_CAP_ID     = 8'h05;
  localparam logic [7:0]  MPCR_PCIX_CAP_ID    = 8'h07;
  localparam logic [7:0]  MPCR_NEXT_PTR_RST   = 8'h00;  // arbitrary default link value

  // message control fields (bit positions inside the 16-bit control half and field codes)
  localparam int          MPCR_MC_EN_BIT      = 0;
  localparam int          MPCR_MC_64_BIT      = 7;
  localparam logic [2:0]  MPCR_MC_MMC_VAL     = 3'h0;  // one vector requested
  localparam logic [2:0]  MPCR_MC_MME_RST     = 3'h0;

  // pcix command fields
  localparam int          MPCR_CMD_RECOV_BIT  = 0;
  localparam logic [2:0]  MPCR_CMD_SPLIT_RST  = 3'h0;
  localparam logic [1:0]  MPCR_CMD_RDBC_RST   = 2'h0;

  // pcix status bit positions and fixed codes
  localparam int          MPCR_ST_SPLIT_ERR   = 29;
  localparam int          MPCR_ST_UNEXP       = 19;
  localparam int          MPCR_ST_DISCARD     = 18;
  localparam logic [2:0]  MPCR_ST_CUM_READ    = 3'h1;  // 2 kbytes
  localparam logic [2:0]  MPCR_ST_DES_SPLIT   = 3'h4;  // eight
  localparam logic [1:0]  MPCR_ST_DES_RDBC    = 2'h2;  // 2048 bytes
  localparam logic        MPCR_ST_COMPLEX     = 1'b0;  // simple device

  // decoded split limits and read byte counts
  localparam logic [3:0]  MPCR_SPLIT_1        = 4'h1;
  localparam logic [3:0]  MPCR_SPLIT_2        = 4'h2;
  localparam logic [3:0]  MPCR_SPLIT_3        = 4'h3;
  localparam logic [3:0]  MPCR_SPLIT_4        = 4'h4;
  localparam logic [3:0]  MPCR_SPLIT_8        = 4'h8;
  localparam logic [11:0] MPCR_RDBC_512       = 12'h200;
  localparam logic [11:0] MPCR_RDBC_1024      = 12'h400;
  localparam logic [11:0] MPCR_RDBC_2048      = 12'h800;

  // strap capture delay after reset release (cycles through the synchroniser)
  localparam logic [1:0]  MPCR_STRAP_WAIT     = 2'h2;

  // message former states
  typedef enum logic {MPCR_MSG_IDLE, MPCR_MSG_WAIT} mpcr_msg_state_t;

endpackage

/* shared/mpcr_msg_if.sv */
`timescale 1ns/100ps
interface mpcr_msg_if;
  logic        fire;      // one-cycle request to form a message write
  logic [29:0] addr_lo;   // message address bits [31:2]
  logic [31:0] addr_hi;   // upper address, zero selects 32-bit addressing
  logic [15:0] payload;   // message data low half
  logic        busy;      // former holds an unacknowledged message

  modport regs   (output fire, output addr_lo, output addr_hi, output payload, input busy);
  modport former (input fire, input addr_lo, input addr_hi, input payload, output busy);
endinterface

/* design/mpcr_msg_former.sv */
`timescale 1ns/100ps
module mpcr_msg_former
  import mpcr_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   reset,
  mpcr_msg_if.former  msg,
  input  wire logic   msg_ack,
  output logic        msg_valid,
  output logic [63:0] msg_addr,
  output logic        msg_dac,
  output logic [31:0] msg_data
);

  mpcr_msg_state_t state_reg, state_next;  // idle or waiting for ack
  logic [63:0]     addr_reg,  addr_next;   // captured message address
  logic            dac_reg,   dac_next;    // 64-bit address phase needed
  logic [31:0]     data_reg,  data_next;   // captured dword payload

  // next-state logic for the message write
  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    dac_next   = dac_reg;
    data_next  = data_reg;
    case (state_reg)
      MPCR_MSG_IDLE: begin
        // capture the message image on a request
        if (msg.fire) begin
          addr_next  = {msg.addr_hi, msg.addr_lo, 2'b00};
          dac_next   = (msg.addr_hi != 32'h0000_0000);
          data_next  = {16'h0000, msg.payload};
          state_next = MPCR_MSG_WAIT;
        end
      end
      MPCR_MSG_WAIT: begin
        // hold until the bus master takes the write
        if (msg_ack) begin
          state_next = MPCR_MSG_IDLE;
        end
      end
      default: begin
        state_next = MPCR_MSG_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= MPCR_MSG_IDLE;
      addr_reg  <= 64'h0;
      dac_reg   <= 1'b0;
      data_reg  <= 32'h0;
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      dac_reg   <= dac_next;
      data_reg  <= data_next;
    end
  end

  assign msg_valid = (state_reg == MPCR_MSG_WAIT);
  assign msg.busy  = (state_reg == MPCR_MSG_WAIT);
  assign msg_addr  = addr_reg;
  assign msg_dac   = dac_reg;
  assign msg_data  = data_reg;

endmodule // mpcr_msg_former

/* verif/mpcr_msg_sink.sv */
`timescale 1ns/100ps
// far-side bus master: accepts each message write promptly or slowly
module mpcr_msg_sink (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic slow,
  input  wire logic msg_valid,
  output logic      msg_ack
);
  logic [3:0] wait_reg;  // cycles the message has waited

  // one ack pulse per message, after one or eight cycles
  always @(posedge sys_clk) begin
    if (reset || !msg_valid || msg_ack) begin
      wait_reg <= 4'h0;
      msg_ack  <= 1'b0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
      msg_ack  <= (wait_reg == (slow ? 4'h7 : 4'h0));
    end
  end
endmodule // mpcr_msg_sink

/* verif/mpcr_cap_regs_asserts.sv */
`timescale 1ns/100ps
module mpcr_cap_regs_asserts
  import mpcr_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        cfg_rd_en,
  input wire logic [3:0]  cfg_index,
  input wire logic [31:0] cfg_rdata,
  input wire logic        pcix_mode,
  input wire logic        master_dpe_flag,
  input wire logic        seq_prepare,
  input wire logic [3:0]  seq_split_limit,
  input wire logic [11:0] seq_read_bytes,
  input wire logic        irq_request,
  input wire logic        legacy_interrupt_pins_n,
  input wire logic        serr_n,
  input wire logic        msg_valid,
  input wire logic [63:0] msg_addr,
  input wire logic        msg_dac,
  input wire logic [31:0] msg_data
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // parity flag rose in pci-x mode
  sequence s_cause;
    $past(master_dpe_flag) && !$past(master_dpe_flag, 2) && $past(pcix_mode);
  endsequence
  // error strobe lasts one cycle
  sequence s_pulse;
    !serr_n ##1 serr_n;
  endsequence
  property p_serr; $fell(serr_n) |-> s_cause ##0 s_pulse; endproperty
  a_serr: assert property (p_serr) else $error("bad serr pulse");
  property p_align; msg_valid |-> msg_addr[1:0] == 2'h0; endproperty
  a_align: assert property (p_align) else $error("msg addr unaligned");
  property p_dac; msg_valid |-> msg_dac == (msg_addr[63:32] != 32'h0); endproperty
  a_dac: assert property (p_dac) else $error("msg dac wrong");
  property p_data; msg_valid |-> msg_data[31:16] == 16'h0000; endproperty
  a_data: assert property (p_data) else $error("msg upper half set");
  property p_stat; cfg_rd_en && cfg_index == MPCR_IDX_PCIX_STAT |=> cfg_rdata[28:20] == 9'h064;
  endproperty
  a_stat: assert property (p_stat) else $error("fixed status wrong");
  property p_seq; seq_prepare |=> seq_split_limit inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8}
    && seq_read_bytes inside {12'h200, 12'h400, 12'h800}; endproperty
  a_seq: assert property (p_seq) else $error("bad decode");
  property p_hold; !seq_prepare |=> $stable(seq_split_limit) && $stable(seq_read_bytes);
  endproperty
  a_hold: assert property (p_hold) else $error("limits moved");
  property p_legacy; !legacy_interrupt_pins_n |-> $past(irq_request); endproperty
  a_legacy: assert property (p_legacy) else $error("pin without request");
endmodule // mpcr_cap_regs_asserts
bind mpcr_cap_regs mpcr_cap_regs_asserts chk_i (.*);

/* verif/mpcr_cap_regs_tb_top.sv */
`timescale 1ns/100ps
module mpcr_cap_regs_tb_top
  import mpcr_pkg::*;
;
  logic        sys_clk, reset, cfg_wr_en, cfg_rd_en, cfg_type0_cap, slow, msg_ack;
  logic        speed_strap_pin, width_strap_pin, pcix_mode, master_dpe_flag;
  logic        split_err_msg_evt, unexp_split_evt, split_discard_evt, seq_prepare;
  logic        irq_request, legacy_interrupt_pins_n, serr_n, msg_valid, msg_dac;
  logic        cfg_rd_valid;
  logic [3:0]  cfg_index, cfg_be, seq_split_limit;
  logic [31:0] cfg_wdata, cfg_rdata, msg_data;
  logic [7:0]  cap_bus_num;
  logic [4:0]  cap_dev_num;
  logic [2:0]  cap_func_num;
  logic [11:0] seq_read_bytes;
  logic [63:0] msg_addr;
  int          failures, checked, cycles;

  mpcr_cap_regs dut (.*);
  mpcr_msg_sink sink (.sys_clk(sys_clk), .reset(reset), .slow(slow), .msg_valid(msg_valid),
                      .msg_ack(msg_ack));
  always #10 sys_clk = ~sys_clk;
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask
  task automatic cfg_wr(input logic [3:0] i, input logic [3:0] b, input logic [31:0] d);
    @(negedge sys_clk);
    cfg_index = i;
    cfg_be = b;
    cfg_wdata = d;
    cfg_wr_en = 1'b1;
    @(negedge sys_clk);
    cfg_wr_en = 1'b0;
  endtask
  // read one dword and compare the masked answer
  task automatic rd_chk(input logic [3:0] i, input logic [31:0] m, input logic [31:0] e);
    @(negedge sys_clk);
    cfg_index = i;
    cfg_rd_en = 1'b1;
    @(negedge sys_clk);
    cfg_rd_en = 1'b0;
    chk({cfg_rd_valid, cfg_rdata & m}, {1'b1, e});
  endtask
  task automatic t_regs;
    cap_bus_num = 8'ha5;
    cap_dev_num = 5'h13;
    cap_func_num = 3'h6;
    pulse(cfg_type0_cap);
    cfg_wr(MPCR_IDX_MSI_ADDR_L, 4'hf, 32'hdeadbeef);
    rd_chk(MPCR_IDX_MSI_ADDR_L, 32'hffffffff, 32'hdeadbeec);
    cfg_wr(MPCR_IDX_PCIX_CMD, 4'h3, 32'h0000ffff);
    rd_chk(MPCR_IDX_PCIX_CMD, 32'h0000ffff, 32'h00000007);
    rd_chk(MPCR_IDX_MSI_CTRL, 32'h000e0000, 32'h0);
    cfg_wr(MPCR_IDX_PCIX_STAT, 4'hf, 32'hdfffffff);
    rd_chk(MPCR_IDX_PCIX_STAT, 32'h1fffffff, 32'h0642a59e);
  endtask
  task automatic t_flags;
    pulse(split_err_msg_evt);
    pulse(unexp_split_evt);
    pulse(split_discard_evt);
    cfg_wr(MPCR_IDX_PCIX_STAT, 4'hf, 32'h0);
    rd_chk(MPCR_IDX_PCIX_STAT, 32'h200c0000, 32'h200c0000);
    cfg_wr(MPCR_IDX_PCIX_STAT, 4'hf, 32'h00080000);
    rd_chk(MPCR_IDX_PCIX_STAT, 32'h200c0000, 32'h20040000);
    cfg_wr(MPCR_IDX_PCIX_STAT, 4'hf, 32'h20040000);
    rd_chk(MPCR_IDX_PCIX_STAT, 32'h200c0000, 32'h0);
    // event and write-one clear on one edge: the set must win
    fork
      pulse(unexp_split_evt);
      cfg_wr(MPCR_IDX_PCIX_STAT, 4'h4, 32'h00080000);
    join
    rd_chk(MPCR_IDX_PCIX_STAT, 32'h200c0000, 32'h00080000);
  endtask
  task automatic t_seq;
    logic [3:0] lim [8];
    lim = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h1, 4'h1, 4'h1};
    for (int c = 0; c < 8; c++) begin
      cfg_wr(MPCR_IDX_PCIX_CMD, 4'h4, {9'h0, 3'(c), 2'(c), 18'h0});
      pulse(seq_prepare);
      chk({seq_split_limit, seq_read_bytes}, {lim[c], 12'h200 << (c % 4 % 3)});
    end
    cfg_wr(MPCR_IDX_PCIX_CMD, 4'h4, 32'h00480000);
    chk({seq_split_limit, seq_read_bytes}, {4'h1, 12'h200});
    pulse(seq_prepare);
    chk({seq_split_limit, seq_read_bytes}, {4'h8, 12'h800});
  endtask
  task automatic t_serr;
    // pass 0: no recovery; pass 1: recovery on; pass 2: plain pci mode
    for (int r = 0; r < 3; r++) begin
      pcix_mode = (r != 2);
      cfg_wr(MPCR_IDX_PCIX_CMD, 4'h4, 32'(r[0]) << 16);
      @(negedge sys_clk);
      master_dpe_flag = 1'b1;
      @(negedge sys_clk);
      chk(serr_n, r != 0);
      @(negedge sys_clk);
      chk(serr_n, 1'b1);
      master_dpe_flag = 1'b0;
    end
  endtask
  task automatic t_msg;
    cfg_wr(MPCR_IDX_MSI_DATA, 4'hf, 32'hffff1234);
    irq_request = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({legacy_interrupt_pins_n, msg_valid}, 2'h0);
    cfg_wr(MPCR_IDX_MSI_CTRL, 4'h4, 32'h00010000);
    @(negedge sys_clk);
    chk(legacy_interrupt_pins_n, 1'b1);
    for (int h = 0; h < 2; h++) begin
      slow = h[0];
      cfg_wr(MPCR_IDX_MSI_ADDR_H, 4'hf, 32'(h));
      irq_request = 1'b0;
      @(negedge sys_clk);
      irq_request = 1'b1;
      repeat (8) if (!msg_valid) @(negedge sys_clk);
      chk({msg_valid, msg_dac, msg_addr, msg_data},
          {1'b1, h[0], 32'(h), 32'hdeadbeec, 32'h00001234});
      repeat (12) if (msg_valid) @(negedge sys_clk);
      chk(msg_valid, 1'b0);
    end
  endtask
  // main sequence
  initial begin
    {sys_clk, cfg_wr_en, cfg_rd_en, cfg_type0_cap, slow, speed_strap_pin, pcix_mode} = '0;
    {master_dpe_flag, split_err_msg_evt, unexp_split_evt, split_discard_evt} = '0;
    {seq_prepare, irq_request, cfg_index, cfg_be, cfg_wdata} = '0;
    {cap_bus_num, cap_dev_num, cap_func_num} = '0;
    width_strap_pin = 1'b1;
    reset = 1'b1;
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_regs();
    t_flags();
    t_seq();
    t_serr();
    t_msg();
    give_verdict();
  end
endmodule // mpcr_cap_regs_tb_top
